/* File: shared/sync_burst_sram_defines.vh */
// constants for the synchronous burst sram port
`ifndef SYNC_BURST_SRAM_DEFINES_VH
`define SYNC_BURST_SRAM_DEFINES_VH
`define LANES 4
`define LANE_DATA_W 8
`define LANE_W 9
`define BURST_W 2
`define BURST_ONE 2'h1
`define ADDR_W_DEF 19
`define FIFO_DEPTH_DEF 4
`define ST_IDLE 3'h1
`define ST_READ 3'h2
`define ST_WRITE 3'h4
`define SLEEP_CYCLES 2'h2
`define PKG_QUAD 1'b1
`endif

/* File: src/word_fifo.v */
// small valid/ready fifo for write words
`timescale 1ns/1ps
`include "sync_burst_sram_defines.vh"
module word_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = `FIFO_DEPTH_DEF,
    parameter PTR_W = 2
) (
    input wire clk_sys,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [PTR_W:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[PTR_W:0]);
    assign out_valid = (count != {(PTR_W+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (srst) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // word_fifo

/* File: src/sync_burst_sram_port.v */
// synchronous pipelined burst sram port with internal array
// Behaviour
// R01 - byte writes happen only while byte_write_gate_n is sampled low
// R02 - all synchronous inputs are captured on the rising edge of clk_sys
// R03 - burst_advance_n low during a burst steps to the next burst address
// R04 - selected when primary low, secondary high, tertiary low; processor strobe needs primary low
// R05 - secondary and tertiary selects only count in the quad-flat variant
// R06 - output_enable_n low drives data pins, high makes them inputs
// R07 - first clock of a read from deselect keeps outputs undriven; code masks it only from ST_IDLE, after reset or sleep
// R08 - processor strobe loads full address and burst counter seed
// R09 - controller strobe loads full address and burst counter seed
// R10 - both strobes low: only the processor strobe is acted on
// R11 - burst order strap low selects linear, high selects interleaved
// R12 - sleep request enters low-power sleep, contents kept, access ignored
// R13 - input data and parity are registered on the rising clock edge
// R14 - read data comes from the address registered at the previous rise
// R15 - four lanes of eight data bits plus one parity, each lane selected separately
// R16 - all_lanes_write_n low writes every lane
// R17 - two-bit burst counter: linear adds, interleaved xors start with beat
// R18 - processor-strobe writes take write controls and data a cycle later
// R19 - no strobe and advance high holds the burst address
`timescale 1ns/1ps
`include "sync_burst_sram_defines.vh"
module sync_burst_sram_port #(
    parameter ADDR_W = `ADDR_W_DEF,
    parameter QUAD_PACKAGE = `PKG_QUAD,
    parameter FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    input wire clk_sys,
    input wire srst,
    input wire [ADDR_W-1:0] addr,
    input wire processor_addr_strobe_n,
    input wire controller_addr_strobe_n,
    input wire burst_advance_n,
    input wire select_primary_n,
    input wire select_secondary_hi,
    input wire select_tertiary_n,
    input wire all_lanes_write_n,
    input wire byte_write_gate_n,
    input wire lane0_write_select_n,
    input wire lane1_write_select_n,
    input wire lane2_write_select_n,
    input wire lane3_write_select_n,
    input wire output_enable_n,
    input wire burst_order_strap,
    input wire sleep_request,
    input wire [`LANES*`LANE_DATA_W-1:0] lane_data_in,
    input wire [`LANES-1:0] lane_parity_in,
    output reg [`LANES*`LANE_DATA_W-1:0] lane_data_out,
    output reg [`LANES-1:0] lane_parity_out,
    output reg [`LANES-1:0] lane_data_oe,
    output reg sleeping,
    output reg [`BURST_W-1:0] burst_addr_low
);
    localparam WORD_W = `LANES*`LANE_W;
    localparam DEPTH = 1 << ADDR_W;

    reg [WORD_W-1:0] mem [0:DEPTH-1];
    reg [2:0] state;
    reg [ADDR_W-1:0] addr_reg;
    reg [`BURST_W-1:0] burst_start;
    reg [`BURST_W-1:0] beat;
    reg [`BURST_W-1:0] sleep_cnt;
    reg first_read_mask;
    reg interleaved;

    // registered inputs
    reg p_strobe_n;
    reg c_strobe_n;
    reg adv_n;
    reg gw_n;
    reg gate_n;
    reg [`LANES-1:0] lane_sel_n;
    reg sel_ok;
    reg prim_n;
    reg [WORD_W-1:0] din_reg;
    reg [ADDR_W-1:0] addr_in;

    wire [WORD_W-1:0] fifo_word;
    wire fifo_valid;
    wire fifo_in_ready;
    wire [`LANES-1:0] lane_we;
    wire write_req;
    wire proc_take;
    wire ctrl_take;
    wire [`BURST_W-1:0] cur_low;
    wire [ADDR_W-1:0] cur_addr;
    wire [ADDR_W-1:0] fifo_addr;
    reg [ADDR_W-1:0] wr_addr_q [0:FIFO_DEPTH-1];
    reg [1:0] wa_wr;
    reg [1:0] wa_rd;
    reg [WORD_W-1:0] next_read_word;
    integer i;

    // quad-flat variant uses all three selects
    wire sel_now = !select_primary_n && (QUAD_PACKAGE == 0 ||
                   (select_secondary_hi && !select_tertiary_n)); // R04 R05

    always @(posedge clk_sys) begin
        // R02 R13
        p_strobe_n <= processor_addr_strobe_n;
        c_strobe_n <= controller_addr_strobe_n;
        adv_n <= burst_advance_n;
        gw_n <= all_lanes_write_n;
        gate_n <= byte_write_gate_n;
        lane_sel_n <= {lane3_write_select_n, lane2_write_select_n, lane1_write_select_n, lane0_write_select_n};
        sel_ok <= sel_now;
        prim_n <= select_primary_n;
        addr_in <= addr;
        for (i = 0; i < `LANES; i = i + 1) begin
            din_reg[i*`LANE_W +: `LANE_W] <= {lane_parity_in[i], lane_data_in[i*`LANE_DATA_W +: `LANE_DATA_W]}; // R15
        end
    end

    assign proc_take = !p_strobe_n && !prim_n && sel_ok; // R04 R08
    assign ctrl_take = !c_strobe_n && p_strobe_n && sel_ok; // R09 R10
    assign write_req = !gw_n || (!gate_n && (lane_sel_n != {`LANES{1'b1}})); // R01 R16
    assign lane_we = !gw_n ? {`LANES{1'b1}} : (gate_n ? {`LANES{1'b0}} : ~lane_sel_n); // R01 R16
    assign cur_low = interleaved ? (burst_start ^ beat) : (burst_start + beat); // R11 R17
    assign cur_addr = {addr_reg[ADDR_W-1:`BURST_W], cur_low};

    // strap taken on the clock, not under reset
    always @(posedge clk_sys) begin
        interleaved <= burst_order_strap; // R11
    end

    reg write_en_q;
    reg [WORD_W-1:0] wdata_q;

    // write fifo feeds the array so writes are decoupled from the bus
    word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(2)
    ) u_wfifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(write_en_q),
        .in_ready(fifo_in_ready),
        .in_data(wdata_q),
        .out_valid(fifo_valid),
        .out_ready(!sleeping),
        .out_data(fifo_word)
    );
    reg [`LANES-1:0] we_mask_q;
    reg [`LANES-1:0] mask_q [0:FIFO_DEPTH-1];
    assign fifo_addr = wr_addr_q[wa_rd];

    always @(posedge clk_sys) begin
        if (srst) begin
            state <= `ST_IDLE;
            addr_reg <= {ADDR_W{1'b0}};
            burst_start <= {`BURST_W{1'b0}};
            beat <= {`BURST_W{1'b0}};
            first_read_mask <= 1'b0;
            write_en_q <= 1'b0;
            wdata_q <= {WORD_W{1'b0}};
            we_mask_q <= {`LANES{1'b0}};
            wa_wr <= 2'h0;
            wa_rd <= 2'h0;
            sleeping <= 1'b0;
            sleep_cnt <= {`BURST_W{1'b0}};
            burst_addr_low <= {`BURST_W{1'b0}};
        end else begin
            write_en_q <= 1'b0;
            // sleep entry and exit take two cycles
            if (sleep_request != sleeping) begin
                if (sleep_cnt == `SLEEP_CYCLES - 1'b1) begin
                    sleeping <= sleep_request; // R12
                    sleep_cnt <= {`BURST_W{1'b0}};
                end else begin
                    sleep_cnt <= sleep_cnt + 1'b1;
                end
            end else begin
                sleep_cnt <= {`BURST_W{1'b0}};
            end
            if (sleeping) begin
                state <= `ST_IDLE; // R12
                first_read_mask <= 1'b0;
            end else if (proc_take || ctrl_take) begin
                addr_reg <= addr_in; // R08 R09
                burst_start <= addr_in[`BURST_W-1:0];
                beat <= {`BURST_W{1'b0}};
                burst_addr_low <= addr_in[`BURST_W-1:0];
                first_read_mask <= (state == `ST_IDLE); // R07
                if (ctrl_take && write_req) begin
                    state <= `ST_WRITE;
                    write_en_q <= fifo_in_ready;
                    wdata_q <= din_reg;
                    we_mask_q <= lane_we;
                end else if (ctrl_take || !write_req || proc_take) begin
                    state <= `ST_READ; // R18
                end
            end else if (state != `ST_IDLE) begin
                first_read_mask <= 1'b0;
                if (write_req) begin
                    // R18 write controls honoured in the cycle after a strobe
                    state <= `ST_WRITE;
                    write_en_q <= fifo_in_ready;
                    wdata_q <= din_reg;
                    we_mask_q <= lane_we;
                end else begin
                    state <= `ST_READ;
                end
                if (!adv_n) begin
                    beat <= beat + `BURST_ONE; // R03 R17
                    burst_addr_low <= interleaved ? (burst_start ^ (beat + `BURST_ONE)) :
                                      (burst_start + beat + `BURST_ONE);
                end // R19 holds otherwise
            end
            if (write_en_q) begin
                wa_wr <= wa_wr + 1'b1;
            end
            if (fifo_valid && !sleeping) begin
                wa_rd <= wa_rd + 1'b1;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (write_en_q) begin
            wr_addr_q[wa_wr] <= cur_addr;
            mask_q[wa_wr] <= we_mask_q;
        end
    end

    // array update per lane
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : g_lane
            always @(posedge clk_sys) begin
                if (fifo_valid && !sleeping && mask_q[wa_rd][g]) begin
                    mem[fifo_addr][g*`LANE_W +: `LANE_W] <= fifo_word[g*`LANE_W +: `LANE_W]; // R15
                end
            end
        end
    endgenerate

    always @* begin
        next_read_word = mem[cur_addr]; // R14
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            lane_data_out <= {(`LANES*`LANE_DATA_W){1'b0}};
            lane_parity_out <= {`LANES{1'b0}};
            lane_data_oe <= {`LANES{1'b0}};
        end else begin
            for (i = 0; i < `LANES; i = i + 1) begin
                lane_data_out[i*`LANE_DATA_W +: `LANE_DATA_W] <= next_read_word[i*`LANE_W +: `LANE_DATA_W];
                lane_parity_out[i] <= next_read_word[i*`LANE_W + `LANE_DATA_W];
            end
            // R06 R07 drive only for a read, not its first clock from ST_IDLE after reset or sleep
            lane_data_oe <= {`LANES{!output_enable_n && state == `ST_READ && !first_read_mask && !sleeping}};
        end
    end
endmodule // sync_burst_sram_port

/* File: dv/sram_port_chk.sv */
// assertions on the burst sram port outputs
`timescale 1ns/1ps
module sram_port_chk (
    input wire clk_sys,
    input wire srst,
    input wire processor_addr_strobe_n,
    input wire controller_addr_strobe_n,
    input wire burst_advance_n,
    input wire output_enable_n,
    input wire burst_order_strap,
    input wire sleep_request,
    input wire [3:0] lane_data_oe,
    input wire sleeping,
    input wire [1:0] burst_addr_low
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    reg [3:0] hist = 4'h0;
    reg strap_q = 1'b0;
    wire strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
    wire idle = !strobe && burst_advance_n;
    // strobe or strap change seen lately
    wire ev = strobe || burst_order_strap != strap_q;
    wire quiet = hist == 4'h0 && !ev;
    always @(posedge clk_sys) begin
        hist <= {hist[2:0], ev};
        strap_q <= burst_order_strap;
    end
    chk_addr_hold: assert property (idle [*4] |=> $stable(burst_addr_low))
        else $error("burst address moved while idle");
    chk_linear_step: assert property (quiet && !burst_order_strap && $changed(burst_addr_low)
        |-> burst_addr_low == $past(burst_addr_low) + 2'h1) else $error("linear step wrong");
    chk_xor_step: assert property (quiet && burst_order_strap && $changed(burst_addr_low)
        |-> burst_addr_low[0] != $past(burst_addr_low[0])) else $error("interleaved step wrong");
    chk_sleep_enter: assert property ($rose(sleep_request) |-> ##[1:6] sleeping)
        else $error("sleep not entered");
    chk_sleep_exit: assert property ($fell(sleep_request) |-> ##[1:6] !sleeping)
        else $error("sleep not left");
    chk_sleep_frozen: assert property (sleeping [*3] |=> $stable(burst_addr_low))
        else $error("address moved in sleep");
    chk_oe_release: assert property (output_enable_n [*3] |-> lane_data_oe == 4'h0)
        else $error("lanes driven with enable high");
    chk_read_mask: assert property (lane_data_oe == 4'h0 && strobe |=> (lane_data_oe == 4'h0) [*2])
        else $error("first read clock drove lanes");
    cover property ($rose(sleeping));
    cover property ($rose(|lane_data_oe));
    cover property (quiet && $changed(burst_addr_low));
endmodule // sram_port_chk
bind sync_burst_sram_port sram_port_chk u_chk (.*);

/* File: dv/ext_bus_model.sv */
// shared data wire: port drive, host drive or released lines
`timescale 1ns/1ps
module ext_bus_model (
    input wire clk_sys,
    input wire [35:0] port_q,
    input wire [3:0] port_oe,
    input wire [35:0] host_q,
    input wire host_oe,
    output wire [35:0] pin
);
    reg [35:0] last = 36'h0;
    genvar i;
    for (i = 0; i < 36; i = i + 1) begin : g_bit
        // released line shows the inverse of its last level
        assign pin[i] = port_oe[i < 32 ? i / 8 : i - 32] ? port_q[i] : host_oe ? host_q[i] : ~last[i];
    end
    always @(posedge clk_sys) begin
        last <= pin;
    end
endmodule // ext_bus_model

/* File: dv/sync_burst_sram_port_tb.sv */
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module sync_burst_sram_port_tb;
    logic clk_sys = 0, srst = 1, sleep_request = 0, burst_order_strap = 0, output_enable_n = 1;
    logic processor_addr_strobe_n = 1, controller_addr_strobe_n = 1, burst_advance_n = 1;
    logic select_primary_n = 0, select_secondary_hi = 1, select_tertiary_n = 0;
    logic all_lanes_write_n = 1, byte_write_gate_n = 1, host_oe = 0;
    logic [3:0] bw_n = 4'hf;
    logic [5:0] addr = 6'h0;
    logic [35:0] host_q = 36'h0;
    wire [35:0] pin;
    wire lane0_write_select_n = bw_n[0];
    wire lane1_write_select_n = bw_n[1];
    wire lane2_write_select_n = bw_n[2];
    wire lane3_write_select_n = bw_n[3];
    wire [31:0] lane_data_in = pin[31:0];
    wire [3:0] lane_parity_in = pin[35:32];
    wire [31:0] lane_data_out;
    wire [3:0] lane_parity_out, lane_data_oe;
    wire sleeping;
    wire [1:0] burst_addr_low;
    int err_count = 0, checks = 0, cyc_n = 0;
    sync_burst_sram_port #(.ADDR_W(6)) DUT (.*);
    ext_bus_model bus (.clk_sys(clk_sys), .port_q({lane_parity_out, lane_data_out}), .port_oe(lane_data_oe),
        .host_q(host_q), .host_oe(host_oe), .pin(pin));
    initial forever #2 clk_sys = ~clk_sys;
    task chk(input [35:0] got, input [35:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task drv(input bit g, input bit b, input [3:0] m, input [35:0] d, input bit w);
        {all_lanes_write_n, byte_write_gate_n, bw_n, host_q, host_oe} <= {g, b, m, d, w};
        if (w) output_enable_n <= 1;
    endtask
    // one access; processor-strobe writes give controls a cycle late
    task op(input bit p, input [5:0] a, input bit g, input bit b, input [3:0] m, input [35:0] d);
        bit w;
        w = !(g && b);
        // release the lanes a cycle before the host drives data
        if (w) @(posedge clk_sys) output_enable_n <= 1;
        @(posedge clk_sys);
        {addr, processor_addr_strobe_n, controller_addr_strobe_n} <= {a, !p, p};
        if (!p) drv(g, b, m, d, w);
        @(posedge clk_sys);
        {processor_addr_strobe_n, controller_addr_strobe_n} <= 2'h3;
        drv(p ? g : 1'b1, p ? b : 1'b1, p ? m : 4'hf, d, p && w);
        if (p && w) @(posedge clk_sys) drv(1, 1, 4'hf, d, 0);
        if (w) repeat (6) @(posedge clk_sys);
    endtask
    task rd(input [5:0] a, input bit n, input [35:0] e);
        @(posedge clk_sys) output_enable_n <= n;
        op(1, a, 1, 1, 4'hf, 36'h0);
        // strobe decoded, data registered, first-clock mask passed
        repeat (4) @(negedge clk_sys);
        chk(lane_data_oe, n ? 4'h0 : 4'hf);
        if (!n) chk(pin, e);
    endtask
    task t_burst;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk_sys) burst_order_strap <= s[2];
            op(1, {4'h0, s[1:0]}, 1, 1, 4'hf, 36'h0);
            repeat (4) @(negedge clk_sys);
            chk(burst_addr_low, s[1:0]);
            for (int k = 1; k < 4; k++) begin
                @(posedge clk_sys) burst_advance_n <= 0;
                @(posedge clk_sys) burst_advance_n <= 1;
                repeat (4) @(negedge clk_sys);
                chk(burst_addr_low, 2'(s[2] ? s[1:0] ^ k : s[1:0] + k));
            end
        end
        $display("t_burst done");
    endtask
    task t_wr;
        op(0, 6'h05, 0, 1, 4'hf, 36'h9_a5c3_1e7f);
        rd(6'h05, 0, 36'h9_a5c3_1e7f);
        op(0, 6'h05, 1, 1, 4'h0, 36'h0);
        rd(6'h05, 0, 36'h9_a5c3_1e7f);
        op(0, 6'h05, 1, 0, 4'hd, 36'hf_ffff_ffff);
        rd(6'h05, 0, 36'hb_a5c3_ff7f);
        op(1, 6'h09, 0, 1, 4'hf, 36'h3_0f0f_5aa5);
        rd(6'h09, 0, 36'h3_0f0f_5aa5);
        rd(6'h09, 1, 36'h0);
        $display("t_wr done");
    endtask
    task t_prio;
        @(posedge clk_sys);
        {addr, processor_addr_strobe_n, controller_addr_strobe_n} <= {6'h05, 2'h0};
        drv(0, 1, 4'hf, 36'h0, 1);
        @(posedge clk_sys);
        {processor_addr_strobe_n, controller_addr_strobe_n} <= 2'h3;
        drv(1, 1, 4'hf, 36'h0, 0);
        repeat (6) @(posedge clk_sys);
        rd(6'h05, 0, 36'hb_a5c3_ff7f);
        $display("t_prio done");
    endtask
    task t_sel;
        logic [2:0] pat [3] = '{3'b110, 3'b000, 3'b011};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys) {select_primary_n, select_secondary_hi, select_tertiary_n} <= pat[i];
            op(i == 0, 6'h06, 1, 1, 4'hf, 36'h0);
            repeat (4) @(negedge clk_sys);
            chk(burst_addr_low, 2'h1);
        end
        @(posedge clk_sys) {select_primary_n, select_secondary_hi, select_tertiary_n} <= 3'b010;
        $display("t_sel done");
    endtask
    task t_sleep;
        @(posedge clk_sys) sleep_request <= 1;
        repeat (6) @(negedge clk_sys);
        chk(sleeping, 1'b1);
        op(1, 6'h0a, 1, 1, 4'hf, 36'h0);
        repeat (4) @(negedge clk_sys);
        chk(burst_addr_low, 2'h1);
        @(posedge clk_sys) sleep_request <= 0;
        repeat (8) @(negedge clk_sys);
        chk(sleeping, 1'b0);
        rd(6'h05, 0, 36'hb_a5c3_ff7f);
        $display("t_sleep done");
    endtask
    task tally_and_finish;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc_n++;
        if (cyc_n == 4000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 0;
        t_burst;
        t_wr;
        t_prio;
        t_sel;
        t_sleep;
        tally_and_finish;
    end
endmodule // sync_burst_sram_port_tb
